/* hdl/eeprom_pkg.sv */
// Shared constants and types for both ends of the EEPROM link
package eeprom_pkg;
    // Type identifier value is arbitrary
    localparam logic [3:0] TYPE_ID = 4'h5;
    localparam int TYPE_LSB = 4;
    localparam int SEL_HI_BIT = 3;
    localparam int SEL_LO_BIT = 2;
    localparam int MSB_BIT = 1;
    localparam int DIR_BIT = 0;
    localparam int ADDR_W = 17;
    localparam int PAGE_W = 8;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [16:0] ADDR_RST = 17'h00000;
    localparam logic [3:0] ACK_STEP = 4'h8;
    localparam logic [3:0] ACK_DONE = 4'h9;
    localparam int CLK_MHZ = 100;
    localparam int PROG_TIME_US = 1000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int QUARTER_CYCLES = 4;
    typedef enum logic [1:0] {OP_WRITE, OP_CUR_READ, OP_RAND_READ} host_op_t;
endpackage

/* hdl/eeprom_link_if.sv */
// Two-wire link between host and device, open-drain data resolved here
`timescale 1ns/1ns
`default_nettype none
interface eeprom_link_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    logic sda;
    // Pulled high unless an enabled driver pulls low
    assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
    modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
    modport device (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface
`default_nettype wire

/* hdl/sync2.sv */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    if (W < 1) begin : g_bad_w
        $error("W must be positive");
    end
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t q;
    sync_t d;
    always_comb begin
        d.s1 = din;
        d.s2 = q.s1;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign dout = q.s2;
endmodule
`default_nettype wire

/* hdl/eeprom_device.sv */
// Device end: two-wire EEPROM read modes, address counter, write protect
// Operation
// R1 - Programming runs from Stop until next acked address
// R2 - No array access while programming runs
// R3 - Protect input high blocks all programming
// R4 - Protect sampled at Stop; later changes ignored
// R5 - Protected write still acked, no programming
// R6 - Blocked write leaves device ready at once
// R7 - Master opens reads with Start, read direction
// R8 - Counter holds last accessed location plus one
// R9 - Read past top wraps to address zero
// R10 - Current read acks, shifts counter byte MSB first
// R11 - Master no-ack ends read, line released
// R12 - Master then sends Stop or new Start
// R13 - Random read: dummy write, no data, no Stop
// R14 - Repeated Start read returns loaded address byte
// R15 - Each master ack advances and sends next byte
// R16 - Sequential read wraps from top to zero
// R17 - Array holds all ones before any write
// R18 - Address byte: type, selects, address MSB, direction
// R19 - Two word address bytes, high first, each acked
// R20 - Address byte not acked while programming
// R21 - Page write increments low eight bits only
// R22 - Programming length is a clock-count parameter
// R23 - Address counter resets to zero
`timescale 1ns/1ns
`default_nettype none
module eeprom_device #(
    parameter int ADDR_W = eeprom_pkg::ADDR_W,
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Two-wire link
    eeprom_link_if.device link,
    // Board pins
    input wire logic write_protect,
    input wire logic board_select_high,
    input wire logic board_select_low,
    // Status
    output logic programming
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int PW = eeprom_pkg::PAGE_W;
    localparam int PAGE = 1 << PW;
    localparam int CW = $clog2(PROG_CYCLES + 1);

    if (ADDR_W < 9 || ADDR_W > 17) begin : g_bad_addr
        $error("ADDR_W must lie in 9..17");
    end
    if (PROG_CYCLES < 1) begin : g_bad_prog
        $error("PROG_CYCLES must be positive");
    end

    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WAH, ST_WAL, ST_WDATA, ST_READ} dev_st_t;
    typedef struct packed {
        dev_st_t st;
        logic [3:0] cnt;
        logic ack_ph;
        logic [7:0] sh;
        logic [7:0] tx;
        logic rw;
        logic msb;
        logic [7:0] hi;
        logic [ADDR_W-1:0] addr;
        logic got;
        logic busy;
        logic [CW-1:0] prog_cnt;
        logic scl_p;
        logic sda_p;
        logic sda_o;
        logic sda_oe_n;
    } dev_t;

    dev_t q;
    dev_t d;
    // Array and page buffer sit beside the state struct: far too wide to pack
    logic [7:0] mem [DEPTH];
    logic [7:0] pbuf [PAGE];
    logic [PAGE-1:0] pval;
    logic [4:0] syn;
    logic s_scl;
    logic s_sda;
    logic s_wp;
    logic s_bsh;
    logic s_bsl;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic dev_match;
    logic commit;
    logic pb_we;
    logic pb_clr;

    sync2 #(.W(5)) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .din({link.scl, link.sda, write_protect, board_select_high, board_select_low}),
        .dout(syn)
    );
    assign s_scl = syn[4];
    assign s_sda = syn[3];
    assign s_wp = syn[2];
    assign s_bsh = syn[1];
    assign s_bsl = syn[0];

    assign rise = s_scl & ~q.scl_p;
    assign fall = ~s_scl & q.scl_p;
    assign start = s_scl & q.scl_p & q.sda_p & ~s_sda;
    assign stop = s_scl & q.scl_p & ~q.sda_p & s_sda;
    assign dev_match = q.sh[7:eeprom_pkg::TYPE_LSB] == eeprom_pkg::TYPE_ID
        && q.sh[eeprom_pkg::SEL_HI_BIT] == s_bsh
        && q.sh[eeprom_pkg::SEL_LO_BIT] == s_bsl; // R18

    always_comb begin
        d = q;
        commit = 1'b0;
        pb_we = 1'b0;
        pb_clr = 1'b0;
        d.scl_p = s_scl;
        d.sda_p = s_sda;
        d.sda_o = 1'b0;
        if (q.busy) begin
            if (q.prog_cnt == CW'(PROG_CYCLES - 1)) begin
                d.busy = 1'b0; // R22
            end else begin
                d.prog_cnt = q.prog_cnt + CW'(1);
            end
        end
        if (start) begin
            d.st = ST_DEV;
            d.cnt = '0;
            d.ack_ph = 1'b0;
            d.got = 1'b0;
            d.sda_oe_n = 1'b1;
            pb_clr = 1'b1;
        end else if (stop) begin
            // Protect is looked at only here; a running interval never rereads it
            if (q.got && !s_wp) begin // R3 R4
                commit = 1'b1;
                d.busy = 1'b1;
                d.prog_cnt = '0;
            end
            // A blocked write leaves busy clear, so the next command is served
            d.got = 1'b0; // R5 R6
            pb_clr = 1'b1;
            d.st = ST_IDLE;
            d.ack_ph = 1'b0;
            d.sda_oe_n = 1'b1;
        end else begin
            unique case (q.st)
                ST_IDLE: begin
                end
                ST_READ: begin
                    if (rise && q.cnt < eeprom_pkg::ACK_STEP) begin
                        d.cnt = q.cnt + 4'h1;
                        d.tx = {q.tx[6:0], 1'b1};
                    end else if (rise && q.cnt == eeprom_pkg::ACK_STEP) begin
                        if (s_sda) begin
                            d.st = ST_IDLE; // R11
                        end else begin
                            d.cnt = eeprom_pkg::ACK_DONE; // R15
                        end
                    end else if (fall && q.cnt < eeprom_pkg::ACK_STEP) begin
                        d.sda_oe_n = q.tx[7]; // R10
                    end else if (fall && q.cnt == eeprom_pkg::ACK_STEP) begin
                        // Line freed for the master's answer; counter moves past this byte
                        d.sda_oe_n = 1'b1;
                        d.addr = q.addr + ADDR_W'(1); // R8 R9 R16
                    end else if (fall && q.cnt == eeprom_pkg::ACK_DONE) begin
                        d.tx = mem[q.addr]; // R15
                        d.sda_oe_n = mem[q.addr][7];
                        d.cnt = '0;
                    end
                end
                ST_DEV, ST_WAH, ST_WAL, ST_WDATA: begin
                    if (rise && !q.ack_ph && q.cnt != eeprom_pkg::ACK_STEP) begin
                        d.sh = {q.sh[6:0], s_sda};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && !q.ack_ph && q.cnt == eeprom_pkg::ACK_STEP) begin
                        d.ack_ph = 1'b1;
                        d.sda_oe_n = 1'b0; // R5 R19
                        if (q.st == ST_DEV) begin
                            if (!dev_match || q.busy) begin // R1 R2 R20
                                d.ack_ph = 1'b0;
                                d.sda_oe_n = 1'b1;
                                d.st = ST_IDLE;
                            end else begin
                                d.rw = q.sh[eeprom_pkg::DIR_BIT];
                                d.msb = q.sh[eeprom_pkg::MSB_BIT];
                            end
                        end else if (q.st == ST_WAH) begin
                            d.hi = q.sh;
                        end else if (q.st == ST_WAL) begin
                            d.addr = ADDR_W'({q.msb, q.hi, q.sh}); // R14 R19
                        end else begin
                            pb_we = 1'b1;
                            d.got = 1'b1;
                            d.addr = {q.addr[ADDR_W-1:PW], q.addr[PW-1:0] + PW'(1)}; // R21
                        end
                    end else if (fall && q.ack_ph) begin
                        d.ack_ph = 1'b0;
                        d.cnt = '0;
                        d.sda_oe_n = 1'b1;
                        if (q.st == ST_DEV && q.rw) begin
                            d.st = ST_READ;
                            d.tx = mem[q.addr]; // R10 R14
                            d.sda_oe_n = mem[q.addr][7];
                        end else if (q.st == ST_DEV) begin
                            d.st = ST_WAH;
                        end else if (q.st == ST_WAH) begin
                            d.st = ST_WAL;
                        end else begin
                            d.st = ST_WDATA;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.addr <= ADDR_W'(eeprom_pkg::ADDR_RST); // R23
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
            q.sda_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Whole page lands in one edge; the busy window then models the interval
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= eeprom_pkg::ERASED; // R17
            end
            pval <= '0;
        end else begin
            if (commit) begin
                for (int i = 0; i < PAGE; i++) begin
                    if (pval[i]) begin
                        mem[{q.addr[ADDR_W-1:PW], PW'(i)}] <= pbuf[i];
                    end
                end
            end
            if (pb_clr) begin
                pval <= '0;
            end else if (pb_we) begin
                pval[q.addr[PW-1:0]] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (pb_we) begin
            pbuf[q.addr[PW-1:0]] <= q.sh;
        end
    end

    assign link.d_sda_o = q.sda_o;
    assign link.d_sda_oe_n = q.sda_oe_n;
    assign programming = q.busy;
endmodule
`default_nettype wire

/* hdl/eeprom_host.sv */
// Host end: two-wire master issuing writes and the three read kinds
`timescale 1ns/1ns
`default_nettype none
module eeprom_host #(
    parameter int QUARTER = eeprom_pkg::QUARTER_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Two-wire link
    eeprom_link_if.master link,
    // Command
    input wire logic go,
    input wire eeprom_pkg::host_op_t op,
    input wire logic [1:0] dev_sel,
    input wire logic [eeprom_pkg::ADDR_W-1:0] addr,
    input wire logic [8:0] count,
    input wire logic [7:0] wr_data,
    // Answer
    output logic wr_take,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic done,
    output logic nacked
);
    localparam int AW = eeprom_pkg::ADDR_W;
    localparam int TW = $clog2(QUARTER);
    if (QUARTER < 4) begin : g_bad_q
        $error("QUARTER must be at least 4");
    end
    typedef enum logic [3:0] {H_IDLE, H_START, H_DEV, H_WAH, H_WAL, H_WDATA,
        H_RSTART, H_RDEV, H_RDATA, H_STOP} host_st_t;
    typedef struct packed {
        host_st_t st;
        logic [1:0] qtr;
        logic [TW-1:0] tick;
        logic [3:0] step;
        logic [7:0] sh;
        logic [8:0] left;
        eeprom_pkg::host_op_t op;
        logic [1:0] sel;
        logic [AW-1:0] addr;
        logic scl;
        logic sda_o;
        logic sda_oe_n;
        logic wr_take;
        logic [7:0] rd_data;
        logic rd_valid;
        logic busy;
        logic done;
        logic nacked;
    } host_t;
    host_t q;
    host_t d;
    logic s_sda;
    logic adv;
    logic rx;
    logic bitst;
    logic [1:0] nq;
    logic [6:0] dev_hi;

    sync2 #(.W(1)) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .din(link.sda),
        .dout(s_sda)
    );
    assign adv = q.tick == TW'(QUARTER - 1);
    assign nq = q.qtr + 2'd1;
    assign rx = q.st == H_RDATA;
    assign bitst = !(q.st inside {H_IDLE, H_START, H_RSTART, H_STOP});
    assign dev_hi = {eeprom_pkg::TYPE_ID, q.sel, q.addr[AW-1]};

    // Bit cell: q0 set data, q1 clock high, q2 start/stop edge, q3 sample and clock low
    always_comb begin
        d = q;
        d.wr_take = 1'b0;
        d.rd_valid = 1'b0;
        d.done = 1'b0;
        d.tick = adv ? '0 : q.tick + TW'(1);
        if (q.st == H_IDLE) begin
            d.tick = '0;
            if (go) begin
                d.st = H_START;
                d.qtr = 2'd3;
                d.op = op;
                d.sel = dev_sel;
                d.addr = addr;
                d.left = count;
                d.busy = 1'b1;
                d.nacked = 1'b0;
            end
        end else if (adv) begin
            d.qtr = nq;
            unique case (nq)
                2'd0: begin
                    if (!bitst) begin
                        d.sda_oe_n = q.st != H_STOP;
                    end else if (q.step == eeprom_pkg::ACK_STEP) begin
                        d.sda_oe_n = !rx || q.left == 9'd1; // R11
                    end else begin
                        d.sda_oe_n = rx || q.sh[7];
                    end
                end
                2'd1: d.scl = 1'b1;
                2'd2: begin
                    if (!bitst) begin
                        d.sda_oe_n = q.st == H_STOP;
                    end
                end
                2'd3: begin
                    d.scl = q.st == H_STOP;
                    if (q.st == H_STOP) begin
                        d.st = H_IDLE; // R12
                        d.busy = 1'b0;
                        d.done = 1'b1;
                    end else if (q.st == H_START) begin
                        d.st = H_DEV;
                        d.step = '0;
                        d.sh = {dev_hi, q.op == eeprom_pkg::OP_CUR_READ}; // R7
                    end else if (q.st == H_RSTART) begin
                        d.st = H_RDEV;
                        d.step = '0;
                        d.sh = {dev_hi, 1'b1}; // R14
                    end else if (q.step != eeprom_pkg::ACK_STEP) begin
                        d.step = q.step + 4'h1;
                        d.sh = {q.sh[6:0], s_sda};
                    end else begin
                        d.step = '0;
                        if (rx) begin
                            d.rd_data = q.sh;
                            d.rd_valid = 1'b1;
                            d.left = q.left - 9'd1;
                            d.st = q.left == 9'd1 ? H_STOP : H_RDATA; // R15
                        end else if (s_sda) begin
                            d.nacked = 1'b1;
                            d.st = H_STOP;
                        end else if (q.st == H_DEV) begin
                            d.st = q.op == eeprom_pkg::OP_CUR_READ ? H_RDATA : H_WAH;
                            d.sh = q.addr[15:8]; // R19
                        end else if (q.st == H_WAH) begin
                            d.st = H_WAL;
                            d.sh = q.addr[7:0];
                        end else if (q.st == H_WAL && q.op != eeprom_pkg::OP_WRITE) begin
                            d.st = H_RSTART; // R13
                        end else if (q.st == H_RDEV) begin
                            d.st = H_RDATA;
                        end else if (q.st == H_WDATA && q.left == 9'd1) begin
                            d.st = H_STOP;
                        end else begin
                            d.left = q.st == H_WDATA ? q.left - 9'd1 : q.left;
                            d.st = H_WDATA;
                            d.sh = wr_data;
                            d.wr_take = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.scl <= 1'b1;
            q.sda_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.scl = q.scl;
    assign link.m_sda_o = q.sda_o;
    assign link.m_sda_oe_n = q.sda_oe_n;
    assign wr_take = q.wr_take;
    assign rd_data = q.rd_data;
    assign rd_valid = q.rd_valid;
    assign busy = q.busy;
    assign done = q.done;
    assign nacked = q.nacked;
endmodule
`default_nettype wire

/* tb/eeprom_asserts.sv */
// Concurrent checks on the two-wire link and the device status pin
`timescale 1ns/1ns
`default_nettype none
module eeprom_asserts #(
    parameter int PROG_CYCLES = 50
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Link lines
    input wire logic scl,
    input wire logic sda,
    input wire logic d_sda_oe_n,
    // Device pins
    input wire logic write_protect,
    input wire logic programming
);
    logic scl_q;
    logic sda_q;
    logic stop_evt;
    logic [7:0] since_stop_q;
    logic [31:0] prog_run_q;
    assign stop_evt = scl && scl_q && sda && !sda_q;
    // Saturating age of the last Stop, and length of the current busy run
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            since_stop_q <= 8'hff;
            prog_run_q <= 32'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            since_stop_q <= stop_evt ? 8'h00 : since_stop_q + {7'h00, since_stop_q != 8'hff};
            prog_run_q <= programming ? prog_run_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_hold_while_high;
        $rose(scl) |=> $stable(d_sda_oe_n) [*3];
    endproperty
    a_hold_while_high: assert property (p_hold_while_high) else $error("device moved sda, scl high");
    property p_change_after_fall;
        $changed(d_sda_oe_n) |-> !scl && !$past(scl, 2);
    endproperty
    a_change_after_fall: assert property (p_change_after_fall) else $error("device drove early");
    property p_launch_at_stop;
        $rose(programming) |-> since_stop_q <= 8'd12 && d_sda_oe_n;
    endproperty
    a_launch_at_stop: assert property (p_launch_at_stop) else $error("busy without stop");
    property p_protect_blocks;
        stop_evt && write_protect && !programming |=> !programming [*8];
    endproperty
    a_protect_blocks: assert property (p_protect_blocks) else $error("protected write programmed");
    property p_busy_length;
        $fell(programming) |-> prog_run_q >= PROG_CYCLES - 2 && prog_run_q <= PROG_CYCLES + 2;
    endproperty
    a_busy_length: assert property (p_busy_length) else $error("busy run length wrong");
    property p_quiet_while_busy;
        programming |-> d_sda_oe_n;
    endproperty
    a_quiet_while_busy: assert property (p_quiet_while_busy) else $error("device drove while busy");
    property p_busy_not_aborted;
        $rose(programming) |=> programming [*8];
    endproperty
    a_busy_not_aborted: assert property (p_busy_not_aborted) else $error("busy run cut short");
    property p_reset_idle;
        $rose(nrst) |-> d_sda_oe_n && !programming;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("device not idle after reset");
    c_busy: cover property ($rose(programming));
    c_protected_stop: cover property (stop_evt && write_protect);
    c_device_drives: cover property ($fell(d_sda_oe_n));
endmodule
`default_nettype wire

/* tb/tb_serial_eeprom_read_protect.sv */
// Bench joining host and device, with a reference array model
`timescale 1ns/1ns
`default_nettype none
module tb_serial_eeprom_read_protect;
    localparam int AW = 10;
    // Long enough that a poll started right after a write still meets the busy window
    localparam int PROG = 400;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic go = 1'b0;
    eeprom_pkg::host_op_t op = eeprom_pkg::OP_CUR_READ;
    logic [1:0] dev_sel = 2'h0;
    logic [eeprom_pkg::ADDR_W-1:0] addr = '0;
    logic [8:0] count = 9'h001;
    logic [7:0] wr_data;
    logic write_protect = 1'b0;
    logic [1:0] straps = 2'h2;
    logic wr_take, rd_valid, busy, done, nacked, programming;
    logic [7:0] rd_data;
    logic [7:0] mem [0:1023];
    logic [7:0] wq [0:511];
    logic [7:0] rq [$];
    logic [AW-1:0] ctr = '0;
    logic ctr_ok = 1'b1;
    int wdi = 0;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    eeprom_link_if link();
    eeprom_device #(.ADDR_W(AW), .PROG_CYCLES(PROG)) i_eeprom_device (.core_clk(core_clk),
        .nrst(nrst), .link(link), .write_protect(write_protect),
        .board_select_high(straps[1]), .board_select_low(straps[0]),
        .programming(programming));
    eeprom_host #(.QUARTER(4)) i_eeprom_host (.core_clk(core_clk), .nrst(nrst), .link(link),
        .go(go), .op(op), .dev_sel(dev_sel), .addr(addr), .count(count), .wr_data(wr_data),
        .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .done(done),
        .nacked(nacked));
    eeprom_asserts #(.PROG_CYCLES(PROG)) i_eeprom_asserts (.core_clk(core_clk), .nrst(nrst),
        .scl(link.scl), .sda(link.sda), .d_sda_oe_n(link.d_sda_oe_n),
        .write_protect(write_protect), .programming(programming));
    assign wr_data = wq[wdi[8:0]];
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (rd_valid) rq.push_back(rd_data);
        if (wr_take) wdi <= #1 wdi + 1;
        cycles++;
        // Whole run needs about 40k cycles
        if (cycles == 95000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (programming !== 1'b0 && k < 1000) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        if (k >= 1000) errors++;
    endtask
    // Page-relative address: low byte wraps, page bits held
    function automatic logic [AW-1:0] page_addr(input logic [AW-1:0] a, input int k);
        return {a[AW-1:8], a[7:0] + k[7:0]};
    endfunction
    // One host command, then compare against the model
    task automatic run(input eeprom_pkg::host_op_t o, input logic [1:0] s,
            input logic [AW-1:0] a, input int n, input logic ack);
        int k;
        for (k = 0; k < n; k++) wq[k] = 8'($urandom);
        @(posedge core_clk);
        #1;
        go = 1'b1;
        op = o;
        dev_sel = s;
        addr = {7'h00, a};
        count = n[8:0];
        wdi = 0;
        rq.delete();
        @(posedge core_clk);
        #1;
        go = 1'b0;
        check(32'(busy), 32'h1);
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while (done !== 1'b1 && k < 6000);
        if (k >= 6000) errors++;
        check(32'(busy), 32'h0);
        check(32'(nacked), 32'(!ack));
        check(32'(link.sda), 32'h1);
        if (!ack) check(rq.size(), 0);
        else if (o == eeprom_pkg::OP_WRITE) begin
            for (k = 0; k < n && !write_protect; k++) mem[page_addr(a, k)] = wq[k];
            ctr = page_addr(a, n);
            ctr_ok = !write_protect;
        end else begin
            if (o == eeprom_pkg::OP_RAND_READ) ctr = a;
            ctr_ok = 1'b1;
            check(rq.size(), n);
            for (k = 0; k < n && k < rq.size(); k++) begin
                check(32'(rq[k]), 32'(mem[ctr]));
                ctr = ctr + 1'b1;
            end
        end
    endtask
    initial begin
        eeprom_pkg::host_op_t o;
        for (int i = 0; i < 1024; i++) mem[i] = eeprom_pkg::ERASED;
        void'($urandom(27895));
        straps = 2'($urandom);
        repeat (5) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        run(eeprom_pkg::OP_CUR_READ, straps, 10'h000, 3, 1'b1);
        run(eeprom_pkg::OP_RAND_READ, ~straps, 10'h005, 1, 1'b0);
        $display("test reset_and_select done");
        run(eeprom_pkg::OP_WRITE, straps, 10'h1fe, 4, 1'b1);
        run(eeprom_pkg::OP_CUR_READ, straps, 10'h000, 1, 1'b0);
        // Protect rises mid-programming; the page must still land
        write_protect = 1'b1;
        wait_idle();
        write_protect = 1'b0;
        run(eeprom_pkg::OP_RAND_READ, straps, 10'h1fe, 2, 1'b1);
        run(eeprom_pkg::OP_RAND_READ, straps, 10'h100, 2, 1'b1);
        $display("test page_wrap_and_polling done");
        write_protect = 1'b1;
        run(eeprom_pkg::OP_WRITE, straps, 10'h100, 3, 1'b1);
        check(32'(programming), 32'h0);
        run(eeprom_pkg::OP_RAND_READ, straps, 10'h0ff, 4, 1'b1);
        write_protect = 1'b0;
        $display("test protected_write done");
        run(eeprom_pkg::OP_RAND_READ, straps, 10'h3fe, 4, 1'b1);
        run(eeprom_pkg::OP_CUR_READ, straps, 10'h000, 2, 1'b1);
        $display("test top_wrap done");
        for (int i = 0; i < 24; i++) begin
            o = eeprom_pkg::host_op_t'($urandom_range(2));
            if (o == eeprom_pkg::OP_CUR_READ && !ctr_ok) o = eeprom_pkg::OP_RAND_READ;
            write_protect = ($urandom_range(3) == 0);
            run(o, straps, AW'($urandom), $urandom_range(8, 1), 1'b1);
            wait_idle();
        end
        $display("test random_mix done");
        give_verdict();
    end
endmodule
`default_nettype wire
